/* File: sim/dmab_cpu_model.sv */
`timescale 1ns/1ps
module dmab_cpu_model (
    input  wire logic   sys_clk,      // Core clock
    output logic        req_valid,    // Request strobe
    output logic        req_write,    // 1 write, 0 read
    output logic        access_sel,   // 1 banked, 0 window
    output logic        full_move,    // Full-address request
    output logic [7:0]  operand_addr, // Low-order operand
    output logic [7:0]  wr_data,      // Write data
    output logic [11:0] full_addr     // Move address
);
    initial {req_valid, req_write, access_sel, full_move, operand_addr, wr_data, full_addr} = '0;
    // One-cycle request; fields inverted once released so stale values are never trusted
    task automatic issue(input logic w, s, f, input logic [7:0] op, wd, input logic [11:0] fa);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        {req_write, access_sel, full_move} <= {w, s, f};
        {operand_addr, wr_data, full_addr} <= {op, wd, fa};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        {req_write, access_sel, full_move} <= ~{w, s, f};
        {operand_addr, wr_data, full_addr} <= ~{op, wd, fa};
    endtask
endmodule

/* File: sim/dmab_top_asserts.sv */
`timescale 1ns/1ps
module dmab_top_asserts #(parameter int IMPL_BANKS = 16) (
    input wire logic        sys_clk,             // Core clock
    input wire logic        sys_rst,             // Sync reset, high
    input wire logic        req_valid,           // Access this cycle
    input wire logic        req_write,           // 1 write, 0 read
    input wire logic        access_sel,          // 1 banked, 0 window
    input wire logic        full_move,           // Full-address request
    input wire logic        extended_set_enable, // Modified window map
    input wire logic        done,                // Access completed
    input wire logic        unimpl_hit,          // Hit no storage
    input wire logic [7:0]  operand_addr,        // Low-order operand
    input wire logic [7:0]  rd_data,             // Read data
    input wire logic [7:0]  bank_pointer,        // Bank pointer readback
    input wire logic [11:0] full_addr,           // Move address
    input wire logic [11:0] data_addr,           // Resolved address
    input wire logic [2:0]  region,              // One-hot region
    input wire logic [3:0]  addr_mode            // One-hot mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Extended map left out: its low range is indexed, not windowed
    wire window_req = req_valid && !full_move && !access_sel && !extended_set_enable;
    property p_done; !$past(sys_rst) |-> done == $past(req_valid); endproperty
    a_done: assert property (p_done) else $error("done late or extra");
    property p_bank; req_valid && !full_move && access_sel |=> addr_mode == 4'b0010
        && data_addr == {$past(bank_pointer[3:0]), $past(operand_addr)}; endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_win_lo; window_req && !operand_addr[7] |=> addr_mode == 4'b0100
        && data_addr == {4'h0, $past(operand_addr)} && region == 3'b001; endproperty
    a_win_lo: assert property (p_win_lo) else $error("low window wrong");
    property p_win_hi; window_req && operand_addr[7]
        |=> data_addr == {4'hF, $past(operand_addr)} && region == 3'b010; endproperty
    a_win_hi: assert property (p_win_hi) else $error("high window wrong");
    property p_full; req_valid && full_move
        |=> data_addr == $past(full_addr) && addr_mode == 4'b0001; endproperty
    a_full: assert property (p_full) else $error("full move address wrong");
    property p_pad; bank_pointer[7:4] == 4'h0; endproperty
    a_pad: assert property (p_pad) else $error("bank pointer pad set");
    property p_ctrl_zero; done && !$past(req_write) && region == 3'b010
        && data_addr != 12'hFE0 |-> rd_data == 8'h00; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("empty control read");
    property p_unimpl; done |-> unimpl_hit == (region == 3'b100)
        && (!unimpl_hit || $past(req_write) || rd_data == 8'h00); endproperty
    a_unimpl: assert property (p_unimpl) else $error("missing bank wrong");
    property p_hold; !$past(sys_rst) && !$past(req_valid && req_write)
        |-> $stable(bank_pointer); endproperty
    a_hold: assert property (p_hold) else $error("bank pointer moved");
    // Bound kept 13 bits wide so a full set of sixteen banks does not wrap to zero
    property p_scratch; done && region == 3'b001
        |-> {1'b0, data_addr} < 13'(IMPL_BANKS * 256); endproperty
    a_scratch: assert property (p_scratch) else $error("scratch out of range");
    c_unimpl: cover property (done && unimpl_hit);
    c_ctrl: cover property (done && region == 3'b010 && !$past(req_write));
    c_ext: cover property (req_valid && extended_set_enable);
endmodule
bind dmab_top dmab_top_asserts #(.IMPL_BANKS(IMPL_BANKS)) u_asserts (.*);

/* File: sim/dmab_top_bench.sv */
`timescale 1ns/1ps
module dmab_top_bench;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, extended_set_enable = 1'b0;
    logic        req_valid, req_write, access_sel, full_move, done, unimpl_hit;
    logic [7:0]  operand_addr, wr_data, rd_data, bank_pointer;
    logic [11:0] full_addr, data_addr, index_base = 12'h200;
    logic [2:0]  region;
    logic [3:0]  addr_mode;
    int          miscompares = 0, n_tests = 0;
    typedef struct {logic x, w, s, f; logic [7:0] op, wd; logic [11:0] fa, ea;
        logic [2:0] er; logic [7:0] ed;} dmab_row_t;
    // Four banks only, so banks 4 and up show the missing-bank path
    dmab_row_t rows [13] = '{
        '{0, 1, 0, 0, 8'hE0, 8'hF5, 12'h000, 12'hFE0, 3'b010, 8'h00},
        '{0, 1, 1, 0, 8'h23, 8'hA5, 12'h000, 12'h523, 3'b100, 8'h00},
        '{0, 0, 1, 0, 8'h23, 8'h00, 12'h000, 12'h523, 3'b100, 8'h00},
        '{0, 1, 0, 0, 8'h23, 8'h3C, 12'h000, 12'h023, 3'b001, 8'h00},
        '{0, 0, 0, 1, 8'h00, 8'h00, 12'h023, 12'h023, 3'b001, 8'h3C},
        '{0, 0, 0, 0, 8'hF0, 8'h00, 12'h000, 12'hFF0, 3'b010, 8'h00},
        '{0, 0, 0, 0, 8'hE0, 8'h00, 12'h000, 12'hFE0, 3'b010, 8'h05},
        '{0, 1, 0, 1, 8'h00, 8'h77, 12'h3FF, 12'h3FF, 3'b001, 8'h00},
        '{0, 1, 0, 1, 8'h00, 8'h03, 12'hFE0, 12'hFE0, 3'b010, 8'h00},
        '{0, 0, 1, 0, 8'hFF, 8'h00, 12'h000, 12'h3FF, 3'b001, 8'h77},
        '{1, 1, 0, 0, 8'h10, 8'h5A, 12'h000, 12'h210, 3'b001, 8'h00},
        '{0, 0, 0, 1, 8'h00, 8'h00, 12'h210, 12'h210, 3'b001, 8'h5A},
        '{1, 1, 0, 0, 8'h70, 8'h11, 12'h000, 12'h070, 3'b001, 8'h00}};
    dmab_top #(.IMPL_BANKS(4)) u_dut (.*);
    dmab_cpu_model u_cpu (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Expected address mode from the row's own controls
    function automatic logic [3:0] mode_of(input dmab_row_t r);
        if (r.f)
            return 4'b0001;
        if (r.s)
            return 4'b0010;
        if (r.x && r.op < 8'h60)
            return 4'b1000;
        return 4'b0100;
    endfunction
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic pulse_reset(input int n);
        @(posedge sys_clk) sys_rst <= 1'b1;
        repeat (n - 1) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("done", done, 1'b0);
        chk("bank_pointer", bank_pointer, 8'h00);
        chk("region", region, 3'b100);
        chk("addr_mode", addr_mode, 4'b0100);
        chk("rd_data", rd_data, 8'h00);
        chk("data_addr", data_addr, 12'h000);
        chk("unimpl_hit", unimpl_hit, 1'b0);
        $display("Reset test done");
    endtask
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        pulse_reset(8);
        foreach (rows[i]) begin
            @(posedge sys_clk) extended_set_enable <= rows[i].x;
            u_cpu.issue(rows[i].w, rows[i].s, rows[i].f, rows[i].op, rows[i].wd, rows[i].fa);
            #1;
            chk("done", done, 1'b1);
            chk("data_addr", data_addr, rows[i].ea);
            chk("region", region, rows[i].er);
            chk("addr_mode", addr_mode, mode_of(rows[i]));
            chk("unimpl_hit", unimpl_hit, rows[i].er == 3'b100);
            if (!rows[i].w)
                chk("rd_data", rd_data, rows[i].ed);
            $display("Row %0d done", i);
        end
        // Last bank pointer write was 03h through a full-address move
        chk("bank_pointer", bank_pointer, 8'h03);
        // Mid-run reset must leave scratch contents alone
        pulse_reset(2);
        u_cpu.issue(1'b0, 1'b1, 1'b0, 8'h23, 8'h00, 12'h000);
        #1;
        chk("rd_data", rd_data, 8'h3C);
        $display("Retention test done");
        close_out();
    end
endmodule

/* File: verilog/dmab_params.svh */
`ifndef DMAB_PARAMS_SVH
`define DMAB_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Address widths and bank geometry
`define DMAB_ADDR_W          12
`define DMAB_DATA_W          8
`define DMAB_BANK_COUNT      16
`define DMAB_BANK_SIZE       256
`define DMAB_BANK_FIELD_W    4

////////////////////////////////////////////////////////////////////////////////
// Region boundaries
`define DMAB_SCRATCH_BASE    12'h0000
`define DMAB_CTRL_BASE       12'h0F80
`define DMAB_CTRL_TOP        12'h0FFF
`define DMAB_WINDOW_SPLIT    8'h80
`define DMAB_WINDOW_HI_PAGE  12'h0F00
`define DMAB_EXT_SPLIT       8'h60

////////////////////////////////////////////////////////////////////////////////
// Bank pointer register
`define DMAB_BANK_PTR_ADDR   12'h0FE0
`define DMAB_BANK_PTR_RESET  4'h0
`define DMAB_BANK_PTR_PAD    4'h0

`endif

/* File: verilog/dmab_pkg.sv */
package dmab_pkg;

    // Region that a resolved address falls in, one-hot
    typedef enum logic [2:0] {
        DMAB_REGION_SCRATCH = 3'b001,
        DMAB_REGION_CTRL    = 3'b010,
        DMAB_REGION_NONE    = 3'b100
    } dmab_region_t;

    // How the address of an access was formed, one-hot
    typedef enum logic [3:0] {
        DMAB_MODE_FULL   = 4'b0001,
        DMAB_MODE_BANKED = 4'b0010,
        DMAB_MODE_WINDOW = 4'b0100,
        DMAB_MODE_INDEX  = 4'b1000
    } dmab_mode_t;

endpackage

/* File: verilog/dmab_top.sv */
`timescale 1ns/1ps
`include "dmab_params.svh"

module dmab_top
    import dmab_pkg::*;
#(
    parameter int IMPL_BANKS = 16
) (
    input  wire logic                      sys_clk,             // Core clock
    input  wire logic                      sys_rst,             // Sync reset, high
    input  wire logic                      req_valid,           // Access this cycle
    input  wire logic                      req_write,           // 1 write, 0 read
    input  wire logic                      access_sel,          // 1 banked, 0 window
    input  wire logic [7:0]                operand_addr,        // Low-order operand
    input  wire logic                      full_move,           // Use full_addr
    input  wire logic [`DMAB_ADDR_W-1:0]   full_addr,           // 12-bit move address
    input  wire logic                      extended_set_enable, // Modified window map
    input  wire logic [`DMAB_ADDR_W-1:0]   index_base,          // Base for indexed window
    input  wire logic [`DMAB_DATA_W-1:0]   wr_data,             // Write data
    output logic      [`DMAB_DATA_W-1:0]   rd_data,             // Read data
    output logic                           done,                // Access completed pulse
    output logic      [`DMAB_ADDR_W-1:0]   data_addr,           // Resolved address
    output logic      [2:0]                region,              // One-hot region
    output logic      [3:0]                addr_mode,           // One-hot address mode
    output logic                           unimpl_hit,          // Access hit no storage
    output logic      [`DMAB_DATA_W-1:0]   bank_pointer         // Bank pointer readback
);

    ////////////////////////////////////////////////////////////////////////////
    // Geometry of the scratch area
    // Scratch RAM stops at the control region even with all banks present
    localparam int FULL_BYTES    = IMPL_BANKS * `DMAB_BANK_SIZE;
    localparam int SCRATCH_DEPTH = (FULL_BYTES < int'(`DMAB_CTRL_BASE)) ?
                                   FULL_BYTES : int'(`DMAB_CTRL_BASE);
    localparam int SCRATCH_AW    = $clog2(SCRATCH_DEPTH);
    localparam logic [12:0] SCRATCH_END = 13'(SCRATCH_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [`DMAB_BANK_FIELD_W-1:0] bank_pointer_reg;
    logic [`DMAB_BANK_FIELD_W-1:0] bank_pointer_next;
    logic [`DMAB_DATA_W-1:0]       rd_data_reg;
    logic [`DMAB_DATA_W-1:0]       rd_data_next;
    logic                          done_reg;
    logic [`DMAB_ADDR_W-1:0]       data_addr_reg;
    logic [2:0]                    region_reg;
    logic [3:0]                    addr_mode_reg;
    logic                          unimpl_hit_reg;
    logic                          done_next;
    logic [`DMAB_ADDR_W-1:0]       data_addr_next;
    logic [2:0]                    region_next;
    logic [3:0]                    addr_mode_next;
    logic                          unimpl_hit_next;

    // No reset on purpose: contents survive every reset
    logic [`DMAB_DATA_W-1:0]       scratch_mem [0:SCRATCH_DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // Address forming
    wire [`DMAB_ADDR_W-1:0] operand_wide = {4'h0, operand_addr};

    wire [`DMAB_ADDR_W-1:0] banked_addr = {bank_pointer_reg, operand_addr};

    wire                    window_upper = (operand_addr >= `DMAB_WINDOW_SPLIT);
    wire [`DMAB_ADDR_W-1:0] window_addr  = window_upper ?
                                           (`DMAB_WINDOW_HI_PAGE + operand_wide) :
                                           (`DMAB_SCRATCH_BASE + operand_wide);

    // Indexed part of the extended map; wraps within the 4 KB space
    wire                    index_hit  = extended_set_enable &&
                                         (operand_addr < `DMAB_EXT_SPLIT);
    wire [`DMAB_ADDR_W-1:0] index_addr = index_base + operand_wide;

    // Bank pointer takes no part in the forced path
    wire [`DMAB_ADDR_W-1:0] forced_addr = index_hit ? index_addr : window_addr;

    wire [`DMAB_ADDR_W-1:0] eff_addr = full_move  ? full_addr   :
                                       access_sel ? banked_addr :
                                                    forced_addr;

    wire [3:0] mode_now = full_move  ? DMAB_MODE_FULL   :
                          access_sel ? DMAB_MODE_BANKED :
                          index_hit  ? DMAB_MODE_INDEX  :
                                       DMAB_MODE_WINDOW;

    ////////////////////////////////////////////////////////////////////////////
    // Region decode
    wire in_ctrl    = (eff_addr >= `DMAB_CTRL_BASE);
    wire in_scratch = !in_ctrl && ({1'b0, eff_addr} < SCRATCH_END);
    wire hit_bank_ptr = (eff_addr == `DMAB_BANK_PTR_ADDR);
    wire no_storage = !in_scratch && !in_ctrl;

    wire [SCRATCH_AW-1:0] scratch_idx = eff_addr[SCRATCH_AW-1:0];

    wire [2:0] region_now = in_scratch ? DMAB_REGION_SCRATCH :
                            in_ctrl    ? DMAB_REGION_CTRL    :
                                         DMAB_REGION_NONE;

    wire do_write = req_valid && req_write;
    wire do_read  = req_valid && !req_write;

    wire scratch_we  = do_write && in_scratch;
    wire bank_ptr_we = do_write && hit_bank_ptr;

    wire [`DMAB_DATA_W-1:0] bank_ptr_view = {`DMAB_BANK_PTR_PAD, bank_pointer_reg};

    // Unassigned control locations and missing banks read zero
    wire [`DMAB_DATA_W-1:0] read_mux = in_scratch   ? scratch_mem[scratch_idx] :
                                       hit_bank_ptr ? bank_ptr_view :
                                                      8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    // Upper four written bits are dropped
    assign bank_pointer_next = bank_ptr_we ? wr_data[`DMAB_BANK_FIELD_W-1:0] :
                                             bank_pointer_reg;

    // Read result held until the next read
    assign rd_data_next = do_read ? read_mux : rd_data_reg;

    // Done follows every taken request, whatever it hit
    assign done_next = req_valid;

    // Address, region and mode describe the last request until the next one
    assign data_addr_next  = req_valid ? eff_addr   : data_addr_reg;
    assign region_next     = req_valid ? region_now : region_reg;
    assign addr_mode_next  = req_valid ? mode_now   : addr_mode_reg;
    assign unimpl_hit_next = req_valid ? no_storage : unimpl_hit_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Scratch storage, written in the same cycle the request is taken
    always_ff @(posedge sys_clk) begin
        if (scratch_we) begin
            scratch_mem[scratch_idx] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bank pointer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bank_pointer_reg <= `DMAB_BANK_PTR_RESET;
        end else begin
            bank_pointer_reg <= bank_pointer_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer registers; every access completes one cycle after it is taken,
    // even when it hits nothing, so core status logic sees a normal access
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            data_addr_reg <= 12'h0000;
        end else begin
            data_addr_reg <= data_addr_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            region_reg <= DMAB_REGION_NONE;
        end else begin
            region_reg <= region_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addr_mode_reg <= DMAB_MODE_WINDOW;
        end else begin
            addr_mode_reg <= addr_mode_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unimpl_hit_reg <= 1'b0;
        end else begin
            unimpl_hit_reg <= unimpl_hit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rd_data      = rd_data_reg;
    assign done         = done_reg;
    assign data_addr    = data_addr_reg;
    assign region       = region_reg;
    assign addr_mode    = addr_mode_reg;
    assign unimpl_hit   = unimpl_hit_reg;
    assign bank_pointer = {`DMAB_BANK_PTR_PAD, bank_pointer_reg};

endmodule
